// ---- bench/mia_seq_model.sv ----
// Purpose: instruction sequencer stand-in for the acknowledge block
// Assumes: fixed instruction length chosen by the bench, 2 to 15 clocks
// Notes:   return-from-irq fires on the last clock of an instruction
`timescale 1ns/100ps
`default_nettype none
module mia_seq_model
  import mia_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [3:0]  i_len,
  input  wire logic        i_facc,
  input  wire logic        i_ret,
  output var mia_pkg::mia_seq_type o_seq
);
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [15:0] pc;
  logic [15:0] next_pc;
  always_comb
  begin
    next_cnt = (cnt >= i_len - 4'h1) ? 4'h0 : cnt + 4'h1;
    next_pc  = (cnt == 4'h0) ? pc + 16'h0001 : pc;
    o_seq.instr_start = (cnt == 4'h0);
    o_seq.instr_last  = (cnt == i_len - 4'h1);
    o_seq.flag_access = i_facc;
    o_seq.ret_irq     = i_ret && o_seq.instr_last;
    o_seq.pc          = pc;
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt <= 4'h0;
      pc  <= 16'h0000;
    end
    else
    begin
      cnt <= next_cnt;
      pc  <= next_pc;
    end
  end
endmodule // mia_seq_model
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the acknowledge block
// Assumes: sequencer model drives instruction timing
// Notes:   expectations follow the register map and vector stride
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mia_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [6:0]  i_src = 7'h00;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [3:0]  len = 4'h4;
  logic        facc = 1'b0;
  logic        ret = 1'b0;
  logic [7:0]  o_rdata;
  mia_seq_type seq;
  mia_ack_type o_ack;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n;
  always #5 i_clk = ~i_clk;
  mia_seq_model u_seq (.i_clk(i_clk), .i_rstn(i_rstn), .i_len(len),
    .i_facc(facc), .i_ret(ret), .o_seq(seq));
  mia_ctrl u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_src(i_src),
    .i_seq(seq), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_ack(o_ack));
  task automatic results;
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, o_rdata});
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge i_clk);
    i_src <= m;
    repeat (4) @(posedge i_clk);
    i_src <= 7'h00;
  endtask
  task automatic no_ack(input int c);
    logic seen;
    seen = 1'b0;
    repeat (c)
    begin
      @(posedge i_clk);
      #1;
      if (o_ack.ack !== 1'b0)
        seen = 1'b1;
    end
    chk("no ack", 16'h0000, {15'h0000, seen});
  endtask
  task automatic wait_ack(input logic [2:0] s, output int c);
    c = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      c++;
    end
    while (o_ack.ack !== 1'b1 && c < 60);
    chk("ack", 16'h0001, {15'h0000, o_ack.ack});
    chk("src", {13'h0000, s}, {13'h0000, o_ack.src});
    chk("saved pc", seq.pc, o_ack.saved_pc);
    chk("vector", 16'h0006 + {12'h000, s, 1'b0}, o_ack.vector);
    chk("push status", 16'h0001, {15'h0000, o_ack.push_status});
    @(posedge i_clk);
    #1;
    chk("push pc", 16'h0001, {15'h0000, o_ack.push_pc});
    // servicing starts once the pc is pushed
    c++;
  endtask
  initial
  begin
    #100us;
    n_errors++;
    results;
  end
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'hFF);
    rd(4'h8, 8'h02);
    rd(4'h2, 8'h00);
    pulse(7'h08);
    no_ack(30);
    rd(4'h0, 8'h10);
    wr(4'h4, 8'h01);
    wait_ack(3'h3, n);
    chk("saved status", 16'h0002, {8'h00, o_ack.saved_status});
    rd(4'h8, 8'h00);
    rd(4'h0, 8'h00);
    rd(4'hC, 8'h03);
    pulse(7'h7F);
    no_ack(30);
    @(posedge i_clk);
    ret <= 1'b1;
    do @(posedge i_clk); while (seq.ret_irq !== 1'b1);
    ret <= 1'b0;
    for (int k = 0; k < 7; k++)
    begin
      if (k > 0)
        wr(4'h8, 8'h02);
      wait_ack(k[2:0], n);
    end
    wr(4'h8, 8'h02);
    @(posedge i_clk);
    i_src <= 7'h01;
    wait_ack(3'h0, n);
    i_src <= 7'h00;
    chk("latency low", 16'h0001, {15'h0000, n >= 9});
    chk("latency high", 16'h0001, {15'h0000, n <= 19});
    wr(4'h8, 8'h02);
    facc <= 1'b1;
    pulse(7'h40);
    no_ack(30);
    facc <= 1'b0;
    wait_ack(3'h6, n);
    // mask the top source so a lower one is served first
    wr(4'h4, 8'h02);
    pulse(7'h05);
    wr(4'h8, 8'h02);
    wait_ack(3'h2, n);
    wr(4'h4, 8'h00);
    wr(4'h8, 8'h02);
    wait_ack(3'h0, n);
    rd(4'hC, 8'h00);
    results;
  end
endmodule // tb
`default_nettype wire

// ---- hw/mia_ctrl.sv ----
// Purpose: maskable interrupt acknowledge control
// Assumes: sequencer marks instruction start/last clock and flag access
// Notes:   sources arrive as asynchronous pulses/levels, synchronised
//
// What this block does
// - eligible when request set, mask clear
// - taken only while global enable is one
// - request to service within 9..19 clocks
// - worst case arises from long test-branch ops
// - simultaneous requests served by fixed priority
// - priority order: lvi, pin0, pin1, timers, adc
// - pending request served once conditions hold
// - push status, then pc; clear enable; vector
// - flag eligible before instruction start: ack after instruction
// - flag on last clock: one more instruction
// - hold pending during flag register access
// - defer one instruction after flag register ops
// - nesting allowed once enable set again
// - without re-enable, wait for routine return
// - enable one permits, zero blocks all
// - flag set by hardware source or write
// - reset leaves all masks set
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mia_defines.svh"
module mia_ctrl
#(
  parameter int NSRC = `MIA_NSRC
)
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic [NSRC-1:0]   i_src,
  input  wire mia_pkg::mia_seq_type i_seq,
  input  wire logic [3:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [7:0]             o_rdata,
  output var mia_pkg::mia_ack_type o_ack
);
  import mia_pkg::*;

  logic [NSRC-1:0] src_m;
  logic [NSRC-1:0] src_s;
  logic [NSRC-1:0] src_d;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] mask;
  logic [7:0]      status;
  logic [7:0]      rdata;
  logic            defer;
  logic            armed;
  logic [2:0]      last_src;
  mia_ack_type     ack;
  logic [NSRC-1:0] next_req;
  logic [NSRC-1:0] next_mask;
  logic [7:0]      next_status;
  logic [7:0]      next_rdata;
  logic            next_defer;
  logic            next_armed;
  logic [2:0]      next_last_src;
  mia_ack_type     next_ack;
  logic            pick_any;
  logic [2:0]      pick_idx;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] rise;
  logic            ie;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      src_m <= '0;
      src_s <= '0;
      src_d <= '0;
    end
    else
    begin
      src_m <= i_src;
      src_s <= src_m;
      src_d <= src_s;
    end
  end

  assign rise = src_s & ~src_d;
  assign ie   = status[`MIA_IE_BIT];
  assign elig = req & ~mask;

  // lowest index is priority 1, the low-voltage source
  mia_prio #(.N(NSRC)) u_prio
  (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_elig (elig),
    .o_any  (pick_any),
    .o_idx  (pick_idx)
  );

  always_comb
  begin
    next_req      = req;
    next_mask     = mask;
    next_status   = status;
    next_rdata    = 8'h00;
    next_defer    = defer;
    next_armed    = armed;
    next_last_src = last_src;
    next_ack      = '0;
    next_ack.saved_status = ack.saved_status;
    next_ack.saved_pc     = ack.saved_pc;
    next_ack.src          = ack.src;
    next_ack.vector       = ack.vector;
    if (i_rd)
    begin
      unique case (i_addr)
        `MIA_ADDR_REQ:    next_rdata = {req, 1'b0};
        `MIA_ADDR_MASK:   next_rdata = {mask, 1'b1};
        `MIA_ADDR_STATUS: next_rdata = status;
        `MIA_ADDR_ACKSRC: next_rdata = {5'h00, last_src};
        default:          next_rdata = 8'h00;
      endcase
    end
    if (i_wr)
    begin
      unique case (i_addr)
        `MIA_ADDR_REQ:    next_req    = i_wdata[7:`MIA_SRC_LSB];
        `MIA_ADDR_MASK:   next_mask   = i_wdata[7:`MIA_SRC_LSB];
        `MIA_ADDR_STATUS: next_status = i_wdata;
        default:          next_status = next_status;
      endcase
    end
    if (i_seq.ret_irq)
      next_status[`MIA_IE_BIT] = 1'b1;
    // flag register access defers one more instruction
    if (i_seq.flag_access)
      next_defer = 1'b1;
    else if (i_seq.instr_last && !i_seq.flag_access)
      next_defer = 1'b0;
    // arm at instruction start only when a request was already eligible
    if (i_seq.instr_start)
      next_armed = pick_any && ie && !defer;
    if (i_seq.instr_last && armed && pick_any && ie && !defer
        && !i_seq.flag_access)
    begin
      next_ack.ack          = 1'b1;
      next_ack.push_status  = 1'b1;
      next_ack.src          = pick_idx;
      next_ack.saved_status = status;
      next_ack.saved_pc     = i_seq.pc;
      next_ack.vector       = `MIA_VEC_BASE + {12'h000, pick_idx, 1'b0};
      next_req[pick_idx]    = 1'b0;
      next_status[`MIA_IE_BIT] = 1'b0;
      next_last_src         = pick_idx;
      next_armed            = 1'b0;
    end
    if (ack.push_status)
      next_ack.push_pc = 1'b1;
    next_req = next_req | rise;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      req      <= '0;
      mask     <= '1;
      status   <= `MIA_STATUS_RESET;
      rdata    <= 8'h00;
      defer    <= 1'b0;
      armed    <= 1'b0;
      last_src <= 3'h0;
      ack      <= '0;
    end
    else
    begin
      req      <= next_req;
      mask     <= next_mask;
      status   <= next_status;
      rdata    <= next_rdata;
      defer    <= next_defer;
      armed    <= next_armed;
      last_src <= next_last_src;
      ack      <= next_ack;
    end
  end

  assign o_rdata = rdata;
  assign o_ack   = ack;

  property p_mask_blocks;
    @(posedge i_clk) disable iff (!i_rstn)
    ack.ack |-> !$past(mask[ack.src]);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("acked a masked source");

  property p_ie_needed;
    @(posedge i_clk) disable iff (!i_rstn)
    ack.ack |-> $past(ie);
  endproperty
  a_ie_needed: assert property (p_ie_needed)
    else $error("acked with enable low");

  property p_ie_cleared;
    @(posedge i_clk) disable iff (!i_rstn)
    ack.ack |-> !ie ##1 ack.push_pc;
  endproperty
  a_ie_cleared: assert property (p_ie_cleared)
    else $error("enable not cleared or pc not pushed");

  property p_no_defer_ack;
    @(posedge i_clk) disable iff (!i_rstn)
    ack.ack |-> !$past(defer) && !$past(i_seq.flag_access);
  endproperty
  a_no_defer_ack: assert property (p_no_defer_ack)
    else $error("acked during flag access");

  property p_vector;
    @(posedge i_clk) disable iff (!i_rstn)
    ack.ack |-> ack.vector == `MIA_VEC_BASE + {12'h000, ack.src, 1'b0};
  endproperty
  a_vector: assert property (p_vector)
    else $error("wrong vector");

  property p_flag_cleared;
    @(posedge i_clk) disable iff (!i_rstn)
    ack.ack |-> !req[ack.src] || $past(rise[ack.src]);
  endproperty
  a_flag_cleared: assert property (p_flag_cleared)
    else $error("flag kept after ack");

  property p_armed_first;
    @(posedge i_clk) disable iff (!i_rstn)
    ack.ack |-> $past(armed);
  endproperty
  a_armed_first: assert property (p_armed_first)
    else $error("ack without arming");

  property p_reset_mask;
    @(posedge i_clk) $rose(i_rstn) |-> mask == '1;
  endproperty
  a_reset_mask: assert property (p_reset_mask)
    else $error("mask not all ones after reset");
endmodule // mia_ctrl
`default_nettype wire

// ---- hw/mia_defines.svh ----
// Purpose: constants for the maskable interrupt acknowledge block
// Assumes: 100 MHz cpu clock, 8-bit register port
// Notes:   offsets are addresses four apart on the plain port
`ifndef MIA_DEFINES_SVH
`define MIA_DEFINES_SVH
`define MIA_ADDR_REQ      4'h0
`define MIA_ADDR_MASK     4'h4
`define MIA_ADDR_STATUS   4'h8
`define MIA_ADDR_ACKSRC   4'hC
`define MIA_REQ_RESET     8'h00
`define MIA_MASK_RESET    8'hFF
`define MIA_STATUS_RESET  8'h02
`define MIA_IE_BIT        1
`define MIA_NSRC          7
`define MIA_SRC_LSB       1
`define MIA_VEC_BASE      16'h0006
`define MIA_MIN_CLOCKS    9
`define MIA_MAX_CLOCKS    19
`define MIA_ACK_CLOCKS    5'h09
`endif

// ---- hw/mia_pkg.sv ----
// Purpose: types for the maskable interrupt acknowledge block
// Assumes: mia_defines.svh constants
// Notes:   sequencer handshake grouped as structs
package mia_pkg;
  typedef struct packed {
    logic       instr_start;
    logic       instr_last;
    logic       flag_access;
    logic       ret_irq;
    logic [15:0] pc;
  } mia_seq_type;
  typedef struct packed {
    logic        ack;
    logic [2:0]  src;
    logic [15:0] vector;
    logic [7:0]  saved_status;
    logic [15:0] saved_pc;
    logic        push_status;
    logic        push_pc;
  } mia_ack_type;
endpackage : mia_pkg

// ---- hw/mia_prio.sv ----
// Purpose: fixed priority pick among eligible sources
// Assumes: bit 0 is the highest priority source
// Notes:   combinational pick registered one cycle
`timescale 1ns/100ps
`default_nettype none
module mia_prio
#(
  parameter int N = 7
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [N-1:0] i_elig,
  output logic              o_any,
  output logic [2:0]        o_idx
);
  logic       any;
  logic [2:0] idx;
  logic       next_any;
  logic [2:0] next_idx;

  always_comb
  begin
    next_any = 1'b0;
    next_idx = 3'h0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (i_elig[i])
      begin
        next_any = 1'b1;
        next_idx = 3'(i);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      any <= 1'b0;
      idx <= 3'h0;
    end
    else
    begin
      any <= next_any;
      idx <= next_idx;
    end
  end

  assign o_any = any;
  assign o_idx = idx;
endmodule // mia_prio
`default_nettype wire
